//--- logic/psc_pkg.sv
// constants, register map and carrier types of the system control bank
// assumes one 125 MHz clock and a synchronous active-high reset
package psc_pkg;

	// clock and timing, times in ns
	localparam int CLK_NS          = 8;
	localparam int SEQ_RST_NS      = 80;
	localparam int SEQ_RECOVER_NS  = 40;
	localparam int BOOT_NS         = 800;
	localparam int SEQ_RST_CYC     = (SEQ_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int SEQ_RECOVER_CYC = (SEQ_RECOVER_NS + CLK_NS - 1) / CLK_NS;
	localparam int BOOT_CYC        = (BOOT_NS + CLK_NS - 1) / CLK_NS;

	// management device and register addresses
	localparam logic [4:0]  MMD_VENDOR    = 5'h1E;
	localparam logic [15:0] ADDR_SFT_PD   = 16'h8812;
	localparam logic [15:0] ADDR_SUBSYS   = 16'h8814;
	localparam logic [15:0] ADDR_MAC_RST  = 16'h8815;
	localparam logic [15:0] ADDR_STATUS   = 16'h8818;
	localparam logic [15:0] ADDR_PMG      = 16'h8819;
	localparam logic [15:0] ADDR_MAC_CFG  = 16'h882B;
	localparam logic [15:0] ADDR_DIAG     = 16'h882C;
	localparam logic [15:0] ADDR_PKG      = 16'h8C22;
	localparam logic [15:0] ADDR_MGMT_CTL = 16'h8C30;

	// field positions
	localparam int BIT_TRIGGER    = 0;
	localparam int BIT_READY      = 0;
	localparam int BIT_PD_STATE   = 1;
	localparam int BIT_RGMII      = 0;
	localparam int BIT_RMII       = 4;
	localparam int BIT_MEDIA      = 8;
	localparam int BIT_CLK_GEN    = 14;
	localparam int BIT_CLK50      = 15;

	// fixed values
	localparam logic [15:0] DIAG_UPPER    = 16'h0002;
	localparam logic [5:0]  PKG_CODE      = 6'h02;
	localparam logic [15:0] READ_ZERO     = 16'h0000;

	// one management access, taken in the cycle valid is high
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [4:0]  dev_addr;
		logic [15:0] reg_addr;
		logic [15:0] wdata;
	} psc_mgmt_req_type;

	// answer one cycle after the access
	typedef struct packed {
		logic        valid;
		logic [15:0] rdata;
	} psc_mgmt_rsp_type;

	// strapping pin levels
	typedef struct packed {
		logic clk50;
		logic clk_gen;
		logic media_conv;
		logic rmii;
		logic rgmii;
		logic powerdown;
	} psc_strap_type;

	// mac interface mode flags
	typedef struct packed {
		logic clk50;
		logic clk_gen;
		logic media_conv;
		logic rmii;
		logic rgmii;
	} psc_mac_mode_type;

endpackage

//--- logic/psc_reset_seq.sv
// managed reset sequencer: a reset pulse, a recovery wait, then a done cycle
// assumes start stays high until done has been seen
`timescale 1ns/1ps
module psc_reset_seq #(
	parameter int RST_CYC     = psc_pkg::SEQ_RST_CYC,
	parameter int RECOVER_CYC = psc_pkg::SEQ_RECOVER_CYC
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// request and result
	input  wire logic start,
	output logic      rst_out_reg,
	output logic      done
);
	import psc_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_ASSERT, S_RECOVER, S_DONE} psc_seq_state_type;

	psc_seq_state_type state_reg;
	logic [15:0]       cnt_reg;

	// state walk with one counter shared by both timed phases
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg <= S_IDLE;
			cnt_reg   <= 16'h0000;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					cnt_reg <= 16'h0000;
					if (start) begin
						state_reg <= S_ASSERT;
					end
				end
				S_ASSERT: begin
					cnt_reg <= cnt_reg + 16'h0001;
					if (cnt_reg == 16'(RST_CYC - 1)) begin
						state_reg <= S_RECOVER;
						cnt_reg   <= 16'h0000;
					end
				end
				S_RECOVER: begin
					cnt_reg <= cnt_reg + 16'h0001;
					if (cnt_reg == 16'(RECOVER_CYC - 1)) begin
						state_reg <= S_DONE;
					end
				end
				S_DONE: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// reset output follows the assert phase, one cycle late
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rst_out_reg <= 1'b0;
		end else begin
			rst_out_reg <= (state_reg == S_ASSERT);
		end
	end

	assign done = (state_reg == S_DONE);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_pulse_start: assert property (start && state_reg == S_IDLE |=> ##1 rst_out_reg)
		else $error("reset pulse did not follow start");
endmodule

//--- logic/psc_startup.sv
// start-up and power-down state tracker
// assumes restart is a level held while the subsystem is being reset
`timescale 1ns/1ps
module psc_startup #(
	parameter int BOOT_CYCLES = psc_pkg::BOOT_CYC
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// control
	input  wire logic restart,
	input  wire logic powerdown_req,
	// status
	output logic      ready_reg,
	output logic      pd_state_reg
);
	import psc_pkg::*;

	typedef enum logic [1:0] {S_BOOT, S_READY, S_PDOWN} psc_boot_state_type;

	psc_boot_state_type state_reg;
	logic [15:0]        cnt_reg;

	// boot count, then ready; power-down keeps only management alive
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg <= S_BOOT;
			cnt_reg   <= 16'h0000;
		end else if (restart) begin
			state_reg <= S_BOOT;
			cnt_reg   <= 16'h0000;
		end else begin
			unique case (state_reg)
				S_BOOT: begin
					cnt_reg <= cnt_reg + 16'h0001;
					if (cnt_reg == 16'(BOOT_CYCLES - 1)) begin
						state_reg <= powerdown_req ? S_PDOWN : S_READY;
					end
				end
				S_READY: begin
					if (powerdown_req) begin
						state_reg <= S_PDOWN;
					end
				end
				S_PDOWN: begin
					cnt_reg <= 16'h0000;
					if (!powerdown_req) begin
						state_reg <= S_BOOT;
					end
				end
			endcase
		end
	end

	// status flags from the state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ready_reg    <= 1'b0;
			pd_state_reg <= 1'b0;
		end else begin
			ready_reg    <= (state_reg == S_READY);
			pd_state_reg <= (state_reg == S_PDOWN);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_ready_exclusive: assert property (!(ready_reg && pd_state_reg))
		else $error("ready and power-down shown together");
endmodule

//--- logic/psc_sys_ctrl.sv
// system control and status register bank in the vendor management device
// assumes a Clause 45 access port decoded upstream; straps stable at reset release
// Contract
// - Writing one to the subsystem reset trigger starts a managed subsystem reset and the bit clears itself when it is over.
// - Writing one to the MAC port reset trigger resets only the MAC interface logic and the bit clears itself afterwards.
// - Status bit 1 shows whether the system sits in the software power-down state.
// - Status bit 0 rises only after start-up has finished and reads zero before.
// - Power management bit 0 is read/write, resets to zero, and forces the boot oscillator on.
// - The MAC interface mode bits take their defaults from strapping and software should leave them alone.
// - Configuration bit 8 enables the media converter, which only acts in RMII mode.
// - Bit 15 shows whether the RMII reference clock is 50 MHz or 25 MHz, strapped, for debug.
// - Bit 14 shows whether RMII clock generation is enabled, strapped by default.
// - Diagnostics clock bit 0 is a read/write enable and the register reads 0x0002 after reset.
// - The package register reports code 0x2 in bits 5:0 with the other bits zero.
// - All registers sit in management device 0x1E at their own register addresses.
// - Software power-down bit 0 enters low power while management access stays possible.
`timescale 1ns/1ps
module psc_sys_ctrl #(
	parameter int BOOT_CYCLES = psc_pkg::BOOT_CYC
) (
	// clock and reset
	input  wire logic                      mclk,
	input  wire logic                      sys_rst,
	// management access
	input  wire psc_pkg::psc_mgmt_req_type mgmt_req,
	output psc_pkg::psc_mgmt_rsp_type      mgmt_rsp_reg,
	// strapping pins
	input  wire psc_pkg::psc_strap_type    strap,
	// resets to the rest of the device
	output logic                           subsystem_reset,
	output logic                           mac_port_reset,
	// power, clock and management port control
	output logic                           powerdown_out_reg,
	output logic                           force_boot_oscillator_reg,
	output logic                           diagnostics_clock_enable_reg,
	output logic                           group_address_enable_reg,
	// mac interface mode
	output psc_pkg::psc_mac_mode_type      mac_mode_reg,
	output logic                           media_converter_active_reg,
	// status
	output logic                           system_ready_flag,
	output logic                           powerdown_state_flag
);
	import psc_pkg::*;

	// true when an access of the given kind hits a register of this bank
	function automatic logic hit(input psc_mgmt_req_type r, input logic [15:0] addr,
		input logic wr);
		hit = r.valid && (r.write == wr) && (r.dev_addr == MMD_VENDOR)
			&& (r.reg_addr == addr);
	endfunction

	logic subsys_trigger_reg;
	logic mac_trigger_reg;
	logic software_powerdown_bit_reg;
	logic strap_taken_reg;
	logic subsys_done;
	logic mac_done;
	logic [15:0] rd_next;

	// managed subsystem reset
	psc_reset_seq u_subsys_seq (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.start       (subsys_trigger_reg),
		.rst_out_reg (subsystem_reset),
		.done        (subsys_done)
	);

	// managed MAC interface reset
	psc_reset_seq u_mac_seq (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.start       (mac_trigger_reg),
		.rst_out_reg (mac_port_reset),
		.done        (mac_done)
	);

	// start-up and power-down tracking, restarted by the subsystem reset
	psc_startup #(
		.BOOT_CYCLES (BOOT_CYCLES)
	) u_startup (
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.restart       (subsystem_reset),
		.powerdown_req (software_powerdown_bit_reg),
		.ready_reg     (system_ready_flag),
		.pd_state_reg  (powerdown_state_flag)
	);

	// self-clearing subsystem trigger, a new write beats the clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			subsys_trigger_reg <= 1'b0;
		end else if (hit(mgmt_req, ADDR_SUBSYS, 1'b1) && mgmt_req.wdata[BIT_TRIGGER]) begin
			subsys_trigger_reg <= 1'b1;
		end else if (subsys_done) begin
			subsys_trigger_reg <= 1'b0;
		end
	end

	// self-clearing MAC port trigger, a new write beats the clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mac_trigger_reg <= 1'b0;
		end else if (hit(mgmt_req, ADDR_MAC_RST, 1'b1) && mgmt_req.wdata[BIT_TRIGGER]) begin
			mac_trigger_reg <= 1'b1;
		end else if (mac_done) begin
			mac_trigger_reg <= 1'b0;
		end
	end

	// software power-down bit, default caught from strap after release
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			software_powerdown_bit_reg <= 1'b0;
		end else if (!strap_taken_reg) begin
			software_powerdown_bit_reg <= strap.powerdown;
		end else if (hit(mgmt_req, ADDR_SFT_PD, 1'b1)) begin
			software_powerdown_bit_reg <= mgmt_req.wdata[0];
		end
	end

	// power-down request driven out to the analog and core domains
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			powerdown_out_reg <= 1'b0;
		end else begin
			powerdown_out_reg <= software_powerdown_bit_reg;
		end
	end

	// strap capture marker, set on the first edge after release
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			strap_taken_reg <= 1'b0;
		end else begin
			strap_taken_reg <= 1'b1;
		end
	end

	// mac interface mode flags, loaded from straps, writable afterwards
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mac_mode_reg <= '0;
		end else if (!strap_taken_reg) begin
			mac_mode_reg.rgmii      <= strap.rgmii;
			mac_mode_reg.rmii       <= strap.rmii;
			mac_mode_reg.media_conv <= strap.media_conv;
			mac_mode_reg.clk_gen    <= strap.clk_gen;
			mac_mode_reg.clk50      <= strap.clk50;
		end else if (hit(mgmt_req, ADDR_MAC_CFG, 1'b1)) begin
			mac_mode_reg.rgmii      <= mgmt_req.wdata[BIT_RGMII];
			mac_mode_reg.rmii       <= mgmt_req.wdata[BIT_RMII];
			mac_mode_reg.media_conv <= mgmt_req.wdata[BIT_MEDIA];
			mac_mode_reg.clk_gen    <= mgmt_req.wdata[BIT_CLK_GEN];
			mac_mode_reg.clk50      <= mgmt_req.wdata[BIT_CLK50];
		end
	end

	// media converter acts only in plain RMII mode
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			media_converter_active_reg <= 1'b0;
		end else begin
			media_converter_active_reg <= mac_mode_reg.media_conv && mac_mode_reg.rmii
				&& !mac_mode_reg.rgmii;
		end
	end

	// power management, diagnostics and management port control bits
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			force_boot_oscillator_reg    <= 1'b0;
			diagnostics_clock_enable_reg <= 1'b0;
			group_address_enable_reg     <= 1'b0;
		end else begin
			if (hit(mgmt_req, ADDR_PMG, 1'b1)) begin
				force_boot_oscillator_reg <= mgmt_req.wdata[0];
			end
			if (hit(mgmt_req, ADDR_DIAG, 1'b1)) begin
				diagnostics_clock_enable_reg <= mgmt_req.wdata[0];
			end
			if (hit(mgmt_req, ADDR_MGMT_CTL, 1'b1)) begin
				group_address_enable_reg <= mgmt_req.wdata[0];
			end
		end
	end

	// read mux, reserved bits fixed, unmapped reads zero
	always_comb begin
		rd_next = READ_ZERO;
		if (mgmt_req.dev_addr == MMD_VENDOR) begin
			unique case (mgmt_req.reg_addr)
				ADDR_SFT_PD:   rd_next = {15'h0000, software_powerdown_bit_reg};
				ADDR_SUBSYS:   rd_next = {15'h0000, subsys_trigger_reg};
				ADDR_MAC_RST:  rd_next = {15'h0000, mac_trigger_reg};
				ADDR_STATUS:   rd_next = {14'h0000, powerdown_state_flag,
					system_ready_flag};
				ADDR_PMG:      rd_next = {15'h0000, force_boot_oscillator_reg};
				ADDR_MAC_CFG:  rd_next = {mac_mode_reg.clk50, mac_mode_reg.clk_gen, 5'h00,
					mac_mode_reg.media_conv, 3'h0, mac_mode_reg.rmii, 3'h0,
					mac_mode_reg.rgmii};
				ADDR_DIAG:     rd_next = DIAG_UPPER | {15'h0000,
					diagnostics_clock_enable_reg};
				ADDR_PKG:      rd_next = {10'h000, PKG_CODE};
				ADDR_MGMT_CTL: rd_next = {15'h0000, group_address_enable_reg};
				default:       rd_next = READ_ZERO;
			endcase
		end
	end

	// answer one cycle after every access, data only for reads
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mgmt_rsp_reg <= '0;
		end else begin
			mgmt_rsp_reg.valid <= mgmt_req.valid;
			mgmt_rsp_reg.rdata <= (mgmt_req.valid && !mgmt_req.write) ? rd_next : READ_ZERO;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_subsys_set_clear: assert property (
		hit(mgmt_req, ADDR_SUBSYS, 1'b1) && mgmt_req.wdata[0]
		|=> subsys_trigger_reg ##[2:30] !subsys_trigger_reg)
		else $error("subsystem trigger did not set and clear");
	a_subsys_pulse: assert property (
		$rose(subsys_trigger_reg) |-> ##[1:4] subsystem_reset)
		else $error("subsystem reset did not start");
	a_mac_only: assert property (
		$rose(mac_trigger_reg) |-> ##[1:4] mac_port_reset ##0 !subsystem_reset
			|| subsys_trigger_reg)
		else $error("mac reset did not start alone");
	a_status_read: assert property (
		hit(mgmt_req, ADDR_STATUS, 1'b0)
		|=> mgmt_rsp_reg.rdata == {14'h0000, $past(powerdown_state_flag),
			$past(system_ready_flag)})
		else $error("status read wrong");
	a_ready_after_boot: assert property (
		$rose(subsystem_reset) |=> ##1 !system_ready_flag [*8])
		else $error("ready shown during restart");
	a_osc_follow: assert property (
		hit(mgmt_req, ADDR_PMG, 1'b1) |=> force_boot_oscillator_reg == $past(mgmt_req.wdata[0]))
		else $error("oscillator force not stored");
	a_strap_load: assert property (
		$fell(strap_taken_reg) or (!strap_taken_reg)
		|=> mac_mode_reg.rmii == $past(strap.rmii) && mac_mode_reg.clk50 == $past(strap.clk50))
		else $error("strap not captured");
	a_media_gate: assert property (
		media_converter_active_reg |-> $past(mac_mode_reg.rmii) && $past(mac_mode_reg.media_conv))
		else $error("media converter outside RMII");
	a_diag_read: assert property (
		hit(mgmt_req, ADDR_DIAG, 1'b0)
		|=> mgmt_rsp_reg.rdata == {15'h0001, $past(diagnostics_clock_enable_reg)})
		else $error("diagnostics read wrong");
	a_pkg_read: assert property (
		hit(mgmt_req, ADDR_PKG, 1'b0) |=> mgmt_rsp_reg.rdata == 16'h0002)
		else $error("package code wrong");
	a_rsvd_read: assert property (
		hit(mgmt_req, ADDR_MAC_RST, 1'b0) |=> mgmt_rsp_reg.rdata[15:1] == 15'h0000)
		else $error("reserved bits not zero");
	a_pd_access: assert property (
		powerdown_state_flag && mgmt_req.valid |=> mgmt_rsp_reg.valid)
		else $error("no answer in power-down");

	// read-back, hold and decode checks on the management side
	a_subsys_read: assert property (
		hit(mgmt_req, ADDR_SUBSYS, 1'b0)
		|=> mgmt_rsp_reg.rdata == {15'h0000, $past(subsys_trigger_reg)})
		else $error("subsystem trigger read wrong");
	a_mac_set_clear: assert property (
		hit(mgmt_req, ADDR_MAC_RST, 1'b1) && mgmt_req.wdata[0]
		|=> mac_trigger_reg ##[2:30] !mac_trigger_reg)
		else $error("mac trigger did not set and clear");
	a_pd_state_src: assert property (
		powerdown_state_flag |-> $past(software_powerdown_bit_reg, 2))
		else $error("power-down state without request");
	a_pd_out_follow: assert property (
		powerdown_out_reg == $past(software_powerdown_bit_reg))
		else $error("power-down output lags its bit");
	a_pd_read: assert property (
		hit(mgmt_req, ADDR_SFT_PD, 1'b0)
		|=> mgmt_rsp_reg.rdata == {15'h0000, $past(software_powerdown_bit_reg)})
		else $error("power-down bit read wrong");
	a_osc_read: assert property (
		hit(mgmt_req, ADDR_PMG, 1'b0)
		|=> mgmt_rsp_reg.rdata == {15'h0000, $past(force_boot_oscillator_reg)})
		else $error("oscillator force read wrong");
	a_mode_hold: assert property (
		strap_taken_reg && !hit(mgmt_req, ADDR_MAC_CFG, 1'b1) |=> $stable(mac_mode_reg))
		else $error("mac mode changed without a write");
	a_cfg_reserved: assert property (
		hit(mgmt_req, ADDR_MAC_CFG, 1'b0) |=> mgmt_rsp_reg.rdata[13:9] == 5'h00
			&& mgmt_rsp_reg.rdata[7:5] == 3'h0 && mgmt_rsp_reg.rdata[3:1] == 3'h0)
		else $error("configuration reserved bits not zero");
	a_other_device: assert property (
		mgmt_req.valid && mgmt_req.dev_addr != MMD_VENDOR |=> mgmt_rsp_reg.rdata == 16'h0000)
		else $error("other device answered with data");

	c_subsys_done: cover property (subsys_done);
	c_mac_done: cover property (mac_done);
	c_powerdown: cover property ($rose(powerdown_state_flag));
	c_ready: cover property ($rose(system_ready_flag));
	c_media: cover property ($rose(media_converter_active_reg));
endmodule

//--- verif/psc_host_model.sv
// management master model: issues one register access at a time
// assumes the bank answers within three cycles of taking a request
`timescale 1ns/1ps
module psc_host_model (
	// clock
	input  wire logic                      mclk,
	// management access
	output psc_pkg::psc_mgmt_req_type      mgmt_req,
	input  wire psc_pkg::psc_mgmt_rsp_type mgmt_rsp_reg
);
	import psc_pkg::*;

	// idle request at time zero
	initial begin
		mgmt_req = '0;
	end

	// one access: request stands one cycle, answer picked up within three cycles
	task automatic access(input logic wr, input logic [4:0] dev, input logic [15:0] addr,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		rd = 16'h0000;
		// mode selection is left to the pins, never rewritten
		if (wr && addr == ADDR_MAC_CFG) begin
			ok = 1'b1;
			return;
		end
		@(negedge mclk);
		mgmt_req = '{1'b1, wr, dev, addr, wd}; // normal use targets device 0x1E
		@(posedge mclk);
		for (n = 0; n < 3 && !ok; n++) begin
			@(negedge mclk);
			// released fields flip so no stale value looks like a request
			if (n == 0) begin
				mgmt_req = '{1'b0, ~wr, ~dev, ~addr, ~wd};
			end
			if (mgmt_rsp_reg.valid === 1'b1) begin
				ok = 1'b1;
				rd = mgmt_rsp_reg.rdata;
			end
		end
	endtask
endmodule

//--- verif/tb_psc_sys_ctrl.sv
// self-checking bench of the system control bank
// assumes the host model drives the management port; straps set at each reset
`timescale 1ns/1ps
module tb_psc_sys_ctrl;
	import psc_pkg::*;

	localparam int BOOT = 40;
	localparam logic [15:0] W_ADDR [6] = '{ADDR_PMG, ADDR_DIAG, ADDR_MGMT_CTL, ADDR_PKG,
		ADDR_STATUS, 16'h8816};
	localparam logic [15:0] W_EXP [6] = '{16'h0001, 16'h0003, 16'h0001, 16'h0002,
		16'h0001, 16'h0000};

	logic              mclk;
	logic              sys_rst;
	psc_mgmt_req_type  mgmt_req;
	psc_mgmt_rsp_type  mgmt_rsp_reg;
	psc_strap_type     strap;
	logic              subsystem_reset;
	logic              mac_port_reset;
	logic              powerdown_out_reg;
	logic              force_osc;
	logic              diag_en;
	logic              group_en;
	psc_mac_mode_type  mac_mode;
	logic              media_active;
	logic              ready;
	logic              pd_flag;
	int                fail_count;
	int                n_compared;
	int                cycles;
	int                i;

	// device under test with a short boot count
	psc_sys_ctrl #(.BOOT_CYCLES(BOOT)) u_psc_sys_ctrl (
		.mclk                         (mclk),
		.sys_rst                      (sys_rst),
		.mgmt_req                     (mgmt_req),
		.mgmt_rsp_reg                 (mgmt_rsp_reg),
		.strap                        (strap),
		.subsystem_reset              (subsystem_reset),
		.mac_port_reset               (mac_port_reset),
		.powerdown_out_reg            (powerdown_out_reg),
		.force_boot_oscillator_reg    (force_osc),
		.diagnostics_clock_enable_reg (diag_en),
		.group_address_enable_reg     (group_en),
		.mac_mode_reg                 (mac_mode),
		.media_converter_active_reg   (media_active),
		.system_ready_flag            (ready),
		.powerdown_state_flag         (pd_flag)
	);

	// management master
	psc_host_model u_psc_host_model (
		.mclk         (mclk),
		.mgmt_req     (mgmt_req),
		.mgmt_rsp_reg (mgmt_rsp_reg)
	);

	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// hang guard
	initial begin
		cycles = 0;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			wrap_up();
		end
	end

	// verdict and end of run
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one comparison
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// register write, answer must come
	task automatic reg_wr(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] wd);
		logic [15:0] rd;
		logic        ok;
		u_psc_host_model.access(1'b1, dev, addr, wd, rd, ok);
		check("write answer", 16'h0001, {15'h0000, ok});
	endtask

	// register read compared with an expected word
	task automatic reg_chk(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] exp);
		logic [15:0] rd;
		logic        ok;
		u_psc_host_model.access(1'b0, dev, addr, 16'h0000, rd, ok);
		check("read answer", 16'h0001, {15'h0000, ok});
		check($sformatf("register %h", addr), exp, rd);
	endtask

	// picks one status output by number
	function automatic logic sig(input int which);
		case (which)
			0: return subsystem_reset;
			1: return mac_port_reset;
			2: return ready;
			default: return pd_flag;
		endcase
	endfunction

	// bounded wait for a status output to reach a level
	task automatic wait_for(input int which, input logic lvl, input int limit);
		int n;
		for (n = 0; n < limit && sig(which) !== lvl; n++) begin
			@(negedge mclk);
		end
		check($sformatf("status output %0d", which), {15'h0000, lvl}, {15'h0000, sig(which)});
	endtask

	// main sequence
	initial begin
		fail_count = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		strap = '{clk50: 1'b1, clk_gen: 1'b0, media_conv: 1'b1, rmii: 1'b1, rgmii: 1'b0,
			powerdown: 1'b0};
		repeat (8) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (2) @(negedge mclk);
		// reset values and strap defaults
		reg_chk(MMD_VENDOR, ADDR_STATUS, 16'h0000);
		reg_chk(MMD_VENDOR, ADDR_MAC_CFG, 16'h8110);
		check("mac mode", 16'h0016, {11'h000, mac_mode});
		check("media active", 16'h0001, {15'h0000, media_active});
		reg_chk(MMD_VENDOR, ADDR_SUBSYS, 16'h0000);
		reg_chk(MMD_VENDOR, ADDR_MAC_RST, 16'h0000);
		reg_chk(MMD_VENDOR, ADDR_PMG, 16'h0000);
		reg_chk(MMD_VENDOR, ADDR_DIAG, 16'h0002);
		reg_chk(MMD_VENDOR, ADDR_PKG, 16'h0002);
		wait_for(2, 1'b1, 60);
		reg_chk(MMD_VENDOR, ADDR_STATUS, 16'h0001);
		// all ones into writable, read-only and unmapped places
		for (i = 0; i < 6; i++) begin
			reg_wr(MMD_VENDOR, W_ADDR[i], 16'hFFFF);
			reg_chk(MMD_VENDOR, W_ADDR[i], W_EXP[i]);
		end
		check("oscillator force", 16'h0001, {15'h0000, force_osc});
		check("diag clock", 16'h0001, {15'h0000, diag_en});
		check("group address", 16'h0001, {15'h0000, group_en});
		reg_wr(MMD_VENDOR, ADDR_DIAG, 16'h0000);
		reg_chk(MMD_VENDOR, ADDR_DIAG, 16'h0002);
		check("diag clock off", 16'h0000, {15'h0000, diag_en});
		// other devices are not this bank
		reg_wr(5'h01, ADDR_PMG, 16'h0000);
		reg_chk(5'h1F, ADDR_PKG, 16'h0000);
		reg_chk(MMD_VENDOR, ADDR_PMG, 16'h0001);
		// mac port reset leaves the subsystem alone
		reg_wr(MMD_VENDOR, ADDR_MAC_RST, 16'h0001);
		reg_chk(MMD_VENDOR, ADDR_MAC_RST, 16'h0001);
		wait_for(1, 1'b1, 10);
		check("subsystem quiet", 16'h0000, {15'h0000, subsystem_reset});
		check("ready kept", 16'h0001, {15'h0000, ready});
		wait_for(1, 1'b0, 20);
		repeat (10) @(negedge mclk);
		reg_chk(MMD_VENDOR, ADDR_MAC_RST, 16'h0000);
		// subsystem reset reruns start-up
		reg_wr(MMD_VENDOR, ADDR_SUBSYS, 16'h0001);
		reg_chk(MMD_VENDOR, ADDR_SUBSYS, 16'h0001);
		wait_for(0, 1'b1, 10);
		wait_for(2, 1'b0, 5);
		wait_for(0, 1'b0, 20);
		repeat (10) @(negedge mclk);
		reg_chk(MMD_VENDOR, ADDR_SUBSYS, 16'h0000);
		wait_for(2, 1'b1, 60);
		// software power-down with access still working
		reg_wr(MMD_VENDOR, ADDR_SFT_PD, 16'h0001);
		wait_for(3, 1'b1, 10);
		check("power-down out", 16'h0001, {15'h0000, powerdown_out_reg});
		reg_chk(MMD_VENDOR, ADDR_STATUS, 16'h0002);
		reg_chk(MMD_VENDOR, ADDR_PKG, 16'h0002);
		reg_wr(MMD_VENDOR, ADDR_SFT_PD, 16'h0000);
		wait_for(3, 1'b0, 10);
		wait_for(2, 1'b1, 60);
		reg_chk(MMD_VENDOR, ADDR_STATUS, 16'h0001);
		// second reset: RGMII straps, media path off, held in power-down
		strap = '{clk50: 1'b0, clk_gen: 1'b1, media_conv: 1'b1, rmii: 1'b0, rgmii: 1'b1,
			powerdown: 1'b1};
		sys_rst = 1'b1;
		repeat (8) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (2) @(negedge mclk);
		reg_chk(MMD_VENDOR, ADDR_MAC_CFG, 16'h4101);
		check("mac mode rgmii", 16'h000D, {11'h000, mac_mode});
		check("media inactive", 16'h0000, {15'h0000, media_active});
		reg_chk(MMD_VENDOR, ADDR_PMG, 16'h0000);
		reg_chk(MMD_VENDOR, ADDR_SFT_PD, 16'h0001);
		wait_for(3, 1'b1, 60);
		reg_chk(MMD_VENDOR, ADDR_STATUS, 16'h0002);
		reg_wr(MMD_VENDOR, ADDR_SFT_PD, 16'h0000);
		wait_for(2, 1'b1, 60);
		reg_chk(MMD_VENDOR, ADDR_STATUS, 16'h0001);
		wrap_up();
	end
endmodule
